//--- src/dcff_defines.svh
// Constants of the FIFO status-flag block
`ifndef DCFF_DEFINES_SVH
`define DCFF_DEFINES_SVH
`define DCFF_WORDS       17'h00200
`define DCFF_CNT_W       18
`define DCFF_OFS_W       17
`define DCFF_M_DEFAULT   17'h0007f
`define DCFF_N_DEFAULT   17'h0007f
`define DCFF_CLK_NS      25
`endif

//--- src/dcff_flags.sv
// Status flags of a bus-matching FIFO, single clock domain
`timescale 1ns/1ps
`include "dcff_defines.svh"
// =====================================================================
// Operation
// - Standard mode: almost_full_n low once writes reach D minus m.
// - D is word count; twice that when both ports are bytes.
// - Fall-through: almost_full_n low after D+1-m writes, output word counted.
// - Async timing: almost_full set on write edge, cleared on read edge.
// - Sync timing: almost_full_n changes only on write edges; code follows the count on every clock edge.
// - Standard: almost_empty_n low when n or fewer words held.
// - Fall-through: almost_empty_n low when n+1 or fewer words held.
// - Async timing: almost_empty set on read edge, cleared on write edge.
// - Sync timing: almost_empty_n changes only on read edges; code follows the count on every clock edge.
// - half_full_n low on the write that passes half depth.
// - half_full_n high on the read bringing count to half or less.
// - Standard: half_full_n low after D/2 plus one writes.
// - Fall-through: half_full_n low after D/2 plus two writes.
// - Read data is 18 bits or 9 bits per output width.
// - Full deassertion may lag one write cycle; flags tolerate it.
// - Timing select sampled at master reset: low async, high sync.
// - Flags count in units of the wider port; widths sampled at reset.
// - Big endian reads high byte first; little endian low byte first.
// =====================================================================
module dcff_flags
    import dcff_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    input  wire logic               master_reset_n,
    input  wire logic               partial_reset_n,
    input  wire dcff_pkg::dcff_cfg_t cfg_in,
    input  wire dcff_pkg::dcff_ofs_t full_offset,
    input  wire dcff_pkg::dcff_ofs_t empty_offset,
    input  wire logic               offset_load_n,
    input  wire logic               write_en,
    input  wire logic [17:0]        write_data_in,
    input  wire logic               read_en,
    output logic [17:0]             read_data_out,
    output logic                    read_valid,
    output logic                    full_n,
    output logic                    empty_n,
    output dcff_pkg::dcff_flags_t   flags
);
    import dcff_pkg::*;

    // Twice the byte depth, a power of two so pointers wrap without logic;
    // the flag capacity, not the array size, limits the fill level
    localparam int unsigned MEMW = 4 * `DCFF_WORDS;
    localparam int unsigned MAW  = $clog2(MEMW);

    // =================================================================
    // Configuration caught during master reset
    // =================================================================
    dcff_cfg_t cfg_reg;
    dcff_ofs_t m_reg;
    dcff_ofs_t n_reg;
    logic      rst_any;
    assign rst_any = sys_rst | ~master_reset_n | ~partial_reset_n;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cfg_reg <= '0;
        end else if (!master_reset_n) begin
            cfg_reg <= cfg_in;
        end
    end

    // Offsets survive partial reset, default at master reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !master_reset_n) begin
            m_reg <= `DCFF_M_DEFAULT;
            n_reg <= `DCFF_N_DEFAULT;
        end else if (!offset_load_n) begin
            m_reg <= full_offset;
            n_reg <= empty_offset;
        end
    end

    logic byte_only;
    logic wide_in;
    logic wide_out;
    assign wide_in   = ~cfg_reg.input_width_select;
    assign wide_out  = ~cfg_reg.output_width_select;
    assign byte_only = ~wide_in & ~wide_out;

    // Depth in flag units: the wider port sets the unit
    dcff_cnt_t depth;
    always_comb begin
        depth = byte_only ? dcff_cnt_t'(2 * `DCFF_WORDS) : dcff_cnt_t'(`DCFF_WORDS);
        if (cfg_reg.first_word_fall_through) begin
            depth = depth + dcff_cnt_t'(1);
        end
    end

    // =================================================================
    // Byte storage and bus matching
    // =================================================================
    // Storage is in bytes so every width pairing shares one pointer set
    logic [8:0]  mem [0:MEMW-1];
    logic [17:0] wptr_reg;
    logic [17:0] rptr_reg;
    logic [17:0] bytes_held;
    logic        wr_ok;
    logic        rd_ok;
    logic [17:0] wstep;
    logic [17:0] rstep;
    logic        big_end;

    assign big_end = ~cfg_reg.endian_select_n;
    assign wstep   = wide_in ? 18'h00002 : 18'h00001;
    assign rstep   = wide_out ? 18'h00002 : 18'h00001;
    assign bytes_held = wptr_reg - rptr_reg;
    assign wr_ok   = write_en & full_n;
    assign rd_ok   = read_en & (bytes_held >= rstep);

    // Byte pairs stored in read order: big endian high byte first
    always_ff @(posedge sys_clk) begin
        if (wr_ok) begin
            if (wide_in) begin
                mem[wptr_reg[MAW-1:0]] <= big_end ? write_data_in[17:9]
                                                  : write_data_in[8:0];
                mem[wptr_reg[MAW-1:0] + MAW'(1)] <= big_end ? write_data_in[8:0]
                                                            : write_data_in[17:9];
            end else begin
                mem[wptr_reg[MAW-1:0]] <= write_data_in[8:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst_any) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            if (wr_ok) begin
                wptr_reg <= wptr_reg + wstep;
            end
            if (rd_ok) begin
                rptr_reg <= rptr_reg + rstep;
            end
        end
    end

    // Read data registered; byte mode leaves upper bits zero
    always_ff @(posedge sys_clk) begin
        if (rst_any) begin
            read_data_out <= '0;
            read_valid    <= 1'b0;
        end else begin
            read_valid <= rd_ok;
            if (rd_ok) begin
                if (wide_out) begin
                    read_data_out <= big_end
                        ? {mem[rptr_reg[MAW-1:0]], mem[rptr_reg[MAW-1:0] + MAW'(1)]}
                        : {mem[rptr_reg[MAW-1:0] + MAW'(1)], mem[rptr_reg[MAW-1:0]]};
                end else begin
                    read_data_out <= {9'h000, mem[rptr_reg[MAW-1:0]]};
                end
            end
        end
    end

    // =================================================================
    // Word count in flag units
    // =================================================================
    // One clock serves both sides, so the count is already valid for every
    // flag; a full release lagging one cycle is absorbed by the registers
    dcff_cnt_t   count;
    dcff_cnt_t   count_nx;
    dcff_cnt_t   cap_bytes;
    logic [17:0] held_nx;
    assign count     = (wide_in || wide_out) ? dcff_cnt_t'(bytes_held >> 1)
                                             : dcff_cnt_t'(bytes_held);
    // Level after this edge's transfers: event-driven flags move on the edge itself
    assign held_nx   = bytes_held + (wr_ok ? wstep : 18'h00000) - (rd_ok ? rstep : 18'h00000);
    assign count_nx  = (wide_in || wide_out) ? dcff_cnt_t'(held_nx >> 1)
                                             : dcff_cnt_t'(held_nx);
    // Fall-through adds one word of room for the output register
    assign cap_bytes = byte_only ? depth : dcff_cnt_t'(depth << 1);

    logic      af_cond;
    logic      ae_cond;
    logic      af_nx;
    logic      ae_nx;
    logic      half_nx;
    dcff_cnt_t half;
    dcff_cnt_t half_mark;
    dcff_cnt_t ae_mark;
    assign half      = dcff_cnt_t'(depth >> 1);
    // Fall-through half mark is D/2 + 2 writes, standard is D/2 + 1
    assign half_mark = cfg_reg.first_word_fall_through ? half + dcff_cnt_t'(2)
                                                       : half + dcff_cnt_t'(1);
    assign ae_mark   = cfg_reg.first_word_fall_through ? dcff_cnt_t'(n_reg) + dcff_cnt_t'(1)
                                                       : dcff_cnt_t'(n_reg);
    assign af_cond   = count >= (depth - dcff_cnt_t'(m_reg));
    assign ae_cond   = count <= ae_mark;
    assign af_nx     = count_nx >= (depth - dcff_cnt_t'(m_reg));
    assign ae_nx     = count_nx <= ae_mark;
    assign half_nx   = count_nx >= half_mark;

    // =================================================================
    // Flags and full / empty
    // =================================================================
    // Async mode: assert only on own side edge, release only on far side
    always_ff @(posedge sys_clk) begin
        if (rst_any) begin
            flags <= '{almost_full_n: 1'b1, almost_empty_n: 1'b0, half_full_n: 1'b1};
        end else begin
            if (cfg_reg.flag_timing_select) begin
                flags.almost_full_n  <= ~af_cond;
                flags.almost_empty_n <= ~ae_cond;
            end else begin
                if (af_nx && wr_ok) begin
                    flags.almost_full_n <= 1'b0;
                end else if (!af_nx && rd_ok) begin
                    flags.almost_full_n <= 1'b1;
                end
                if (ae_nx && rd_ok) begin
                    flags.almost_empty_n <= 1'b0;
                end else if (!ae_nx && wr_ok) begin
                    flags.almost_empty_n <= 1'b1;
                end
            end
            if (half_nx && wr_ok) begin
                flags.half_full_n <= 1'b0;
            end else if (!half_nx && rd_ok) begin
                flags.half_full_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst_any) begin
            full_n  <= 1'b1;
            empty_n <= 1'b0;
        end else begin
            // Looks ahead at this edge's transfers, so no write slips past full
            full_n  <= (cap_bytes - held_nx) >= wstep;
            empty_n <= held_nx >= rstep;
        end
    end

    // =================================================================
    // Checks
    // =================================================================
    property p_half_set;
        @(posedge sys_clk) disable iff (rst_any)
        (wr_ok && half_nx) |=> !flags.half_full_n;
    endproperty
    a_half_set: assert property (p_half_set) else $error("half full not set");

    property p_half_clr;
        @(posedge sys_clk) disable iff (rst_any)
        (!flags.half_full_n && rd_ok && !half_nx && !wr_ok) |=> flags.half_full_n;
    endproperty
    a_half_clr: assert property (p_half_clr) else $error("half full not cleared");

    property p_af_sync;
        @(posedge sys_clk) disable iff (rst_any)
        cfg_reg.flag_timing_select |=> (flags.almost_full_n == !$past(af_cond));
    endproperty
    a_af_sync: assert property (p_af_sync) else $error("almost full wrong");

    property p_ae_sync;
        @(posedge sys_clk) disable iff (rst_any)
        cfg_reg.flag_timing_select |=> (flags.almost_empty_n == !$past(ae_cond));
    endproperty
    a_ae_sync: assert property (p_ae_sync) else $error("almost empty wrong");

    property p_af_async;
        @(posedge sys_clk) disable iff (rst_any)
        (!cfg_reg.flag_timing_select && !$past(rst_any) && $fell(flags.almost_full_n))
        |-> $past(wr_ok);
    endproperty
    a_af_async: assert property (p_af_async) else $error("almost full set off write");

    property p_ae_async;
        @(posedge sys_clk) disable iff (rst_any)
        (!cfg_reg.flag_timing_select && !$past(rst_any) && $fell(flags.almost_empty_n))
        |-> $past(rd_ok);
    endproperty
    a_ae_async: assert property (p_ae_async) else $error("almost empty set off read");

    property p_af_free;
        @(posedge sys_clk) disable iff (rst_any)
        (!cfg_reg.flag_timing_select && !$past(rst_any) && $rose(flags.almost_full_n))
        |-> $past(rd_ok);
    endproperty
    a_af_free: assert property (p_af_free) else $error("almost full freed off read");

    property p_ae_free;
        @(posedge sys_clk) disable iff (rst_any)
        (!cfg_reg.flag_timing_select && !$past(rst_any) && $rose(flags.almost_empty_n))
        |-> $past(wr_ok);
    endproperty
    a_ae_free: assert property (p_ae_free) else $error("almost empty freed off write");

    property p_byte_out;
        @(posedge sys_clk) disable iff (rst_any)
        (!wide_out && read_valid) |-> (read_data_out[17:9] == 9'h000);
    endproperty
    a_byte_out: assert property (p_byte_out) else $error("byte output too wide");

    property p_depth;
        @(posedge sys_clk) disable iff (rst_any)
        byte_only |-> (depth >= dcff_cnt_t'(2 * `DCFF_WORDS));
    endproperty
    a_depth: assert property (p_depth) else $error("byte depth not doubled");

endmodule // dcff_flags

//--- src/dcff_pkg.sv
// Types of the FIFO status-flag block
`include "dcff_defines.svh"
package dcff_pkg;
    typedef logic [`DCFF_CNT_W-1:0] dcff_cnt_t;
    typedef logic [`DCFF_OFS_W-1:0] dcff_ofs_t;
    typedef struct packed {
        logic almost_full_n;
        logic almost_empty_n;
        logic half_full_n;
    } dcff_flags_t;
    typedef struct packed {
        logic first_word_fall_through;
        logic flag_timing_select;
        logic input_width_select;
        logic output_width_select;
        logic endian_select_n;
    } dcff_cfg_t;
endpackage

//--- test/dcff_ctrl_model.sv
// Write-side and read-side controller model for the FIFO status-flag block
`timescale 1ns/1ps
module dcff_ctrl_model (
    input  wire logic        sys_clk,
    output logic             write_en,
    output logic [17:0]      write_data_in,
    output logic             read_en
);
    initial begin
        write_en      = 1'b0;
        read_en       = 1'b0;
        write_data_in = 18'h00000;
    end
    // =====================================================================
    // Requests, one cycle each, launched right after a rising edge
    // Released data line shows the inverse so stale data never looks valid
    task automatic put(input logic [17:0] d);
        write_en      <= 1'b1;
        write_data_in <= d;
        @(posedge sys_clk);
        write_en      <= 1'b0;
        write_data_in <= ~d;
    endtask
    task automatic take();
        read_en <= 1'b1;
        @(posedge sys_clk);
        read_en <= 1'b0;
    endtask
endmodule // dcff_ctrl_model

//--- test/tb.sv
// Self-checking bench for the FIFO status-flag block
`timescale 1ns/1ps
module tb;
    import dcff_pkg::*;
    logic        sys_clk, sys_rst, master_reset_n, partial_reset_n, offset_load_n;
    logic        write_en, read_en, read_valid, full_n, empty_n;
    logic [17:0] write_data_in, read_data_out, pend;
    dcff_cfg_t   cfg_in, md;
    dcff_ofs_t   full_offset, empty_offset;
    dcff_flags_t flags;
    logic [17:0] exp_q[$];
    logic [17:0] store_q[$];
    int          miscompares = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          m, n, d_w, d_t, u, wr;
    dcff_cfg_t   modes[6] = '{5'b01000, 5'b10000, 5'b11110, 5'b00010, 5'b00011, 5'b01101};

    dcff_flags i_dcff_flags (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .master_reset_n(master_reset_n), .partial_reset_n(partial_reset_n),
        .cfg_in(cfg_in), .full_offset(full_offset), .empty_offset(empty_offset),
        .offset_load_n(offset_load_n), .write_en(write_en),
        .write_data_in(write_data_in), .read_en(read_en), .read_data_out(read_data_out),
        .read_valid(read_valid), .full_n(full_n), .empty_n(empty_n), .flags(flags));
    dcff_ctrl_model u_ctrl (.sys_clk(sys_clk), .write_en(write_en),
        .write_data_in(write_data_in), .read_en(read_en));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // =====================================================================
    // Reporting
    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp_bit(input string what, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic cmp_data(input logic [17:0] e, input logic [17:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] read_data_out expected %h seen %h", e, g);
        end
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            wrap_up();
        end
    end
    // Byte output only defines the low nine bits
    always @(negedge sys_clk) begin
        if (read_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp_bit("read_valid", 1'b0, read_valid);
            end else begin
                cmp_data(exp_q.pop_front(), md.output_width_select ?
                    {9'h000, read_data_out[8:0]} : read_data_out);
            end
        end
    end
    // =====================================================================
    // Scoreboard and flag expectations, counted in units of the wider port
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic check_flags();
        cmp_bit("almost_full_n", !(u >= d_t - m), flags.almost_full_n);
        cmp_bit("almost_empty_n", !(u <= n + md.first_word_fall_through),
            flags.almost_empty_n);
        cmp_bit("half_full_n", !(u >= d_w / 2 + 1 + md.first_word_fall_through),
            flags.half_full_n);
        cmp_bit("full_n", u != d_t, full_n);
    endtask
    task automatic put_unit(input logic [17:0] d);
        logic [17:0] v;
        v = md.input_width_select ? {9'h000, d[8:0]} : d;
        u_ctrl.put(v);
        wr++;
        if (md.input_width_select == md.output_width_select) begin
            store_q.push_back(v);
        end else if (md.output_width_select) begin
            store_q.push_back(md.endian_select_n ? {9'h000, v[8:0]} : {9'h000, v[17:9]});
            store_q.push_back(md.endian_select_n ? {9'h000, v[17:9]} : {9'h000, v[8:0]});
        end else if (wr % 2 == 1) begin
            pend = v;
        end else begin
            store_q.push_back(md.endian_select_n ? {v[8:0], pend[8:0]} : {pend[8:0], v[8:0]});
        end
        u = (md.input_width_select && !md.output_width_select) ? wr / 2 : wr;
    endtask
    // =====================================================================
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        master_reset_n = 1'b1;
        partial_reset_n = 1'b1;
        offset_load_n = 1'b1;
        cfg_in = 5'h00;
        full_offset = 17'h00000;
        empty_offset = 17'h00000;
        void'($urandom(32'h41caf6c9));
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            md = modes[k];
            m = $urandom_range(1, 31);
            n = $urandom_range(1, 31);
            d_w = (md.input_width_select && md.output_width_select) ? 1024 : 512;
            d_t = d_w + md.first_word_fall_through;
            @(posedge sys_clk);
            cfg_in <= md;
            master_reset_n <= 1'b0;
            repeat (2) @(posedge sys_clk);
            master_reset_n <= 1'b1;
            offset_load_n <= 1'b0;
            full_offset <= dcff_ofs_t'(m);
            empty_offset <= dcff_ofs_t'(n);
            @(posedge sys_clk);
            offset_load_n <= 1'b1;
            wr = 0;
            repeat (4) begin
                put_unit($urandom);
                @(posedge sys_clk);
            end
            partial_reset_n <= 1'b0;
            @(posedge sys_clk);
            partial_reset_n <= 1'b1;
            store_q.delete();
            wr = 0;
            u = 0;
            settle();
            check_flags();
            while (full_n === 1'b1 && wr < 1100) begin
                put_unit($urandom);
                settle();
                check_flags();
            end
            u_ctrl.put(18'h3ffff);
            settle();
            while (store_q.size() > 0) begin
                exp_q.push_back(store_q.pop_front());
                u_ctrl.take();
                settle();
                if (md.input_width_select || !md.output_width_select) begin
                    u--;
                    check_flags();
                end
            end
            u_ctrl.take();
            settle();
            cmp_bit("empty_n", 1'b0, empty_n);
            cmp_bit("queue_drained", 1'b1, exp_q.size() == 0);
        end
        wrap_up();
    end
endmodule // tb
